// ---- dcdcc_consts.vh ----
/*
  Constants for the converter control block: special-function addresses,
  field positions, reset values and pulse-width timing.
  Assumes a 20 MHz core clock and an 8-bit special-function register bus.
*/
`ifndef DCDCC_CONSTS_VH
`define DCDCC_CONSTS_VH

// ****************************************
// Register addresses
// ****************************************
`define DCDCC_PAGE_MAIN 8'h00
`define DCDCC_PAGE_MODE 8'h0f
`define DCDCC_ADDR_CTRL 8'h97
`define DCDCC_ADDR_CFG 8'h96
`define DCDCC_ADDR_MODE 8'h94

// ****************************************
// Control register fields
// ****************************************
`define DCDCC_CTRL_PULSE_HI 7
`define DCDCC_CTRL_PULSE_LO 6
`define DCDCC_CTRL_SWSIZE 5
`define DCDCC_CTRL_RSVD 4
`define DCDCC_CTRL_SYNC 3
`define DCDCC_CTRL_VOLT_HI 2
`define DCDCC_CTRL_VOLT_LO 0
`define DCDCC_CTRL_RESET 8'h21

// ****************************************
// Configuration and mode register fields
// ****************************************
`define DCDCC_CFG_LOW_POWER 7
`define DCDCC_CFG_PEAK_LIMIT 2
`define DCDCC_CFG_RESET 8'h00
`define DCDCC_MODE_BYPASS_FLAG 3
`define DCDCC_MODE_PASSIVE_DIODE 0
`define DCDCC_MODE_WMASK 8'h07
`define DCDCC_MODE_RESET 8'h00

// ****************************************
// Minimum pulse width timing
// ****************************************
`define DCDCC_CLK_MHZ 20
`define DCDCC_PULSE1_NS 20
`define DCDCC_PULSE2_NS 40
`define DCDCC_PULSE3_NS 80
`define DCDCC_NS_TO_CYC(ns) (((ns) * `DCDCC_CLK_MHZ + 999) / 1000)

`endif

// ---- dcdcc_output_voltage_select_decode.v ----
/*
  Decodes the output voltage select code into a target in tens of millivolts.
  Assumes a purely combinational use by the converter control block.
*/
`default_nettype none

module dcdcc_output_voltage_select_decode (
  input wire [2:0] code,
  output reg [8:0] targetCentivolt
);

  always @*
  begin
    case (code)
      3'h0: targetCentivolt = 9'h0b4;
      3'h1: targetCentivolt = 9'h0be;
      3'h2: targetCentivolt = 9'h0c8;
      3'h3: targetCentivolt = 9'h0d2;
      3'h4: targetCentivolt = 9'h0f0;
      3'h5: targetCentivolt = 9'h10e;
      3'h6: targetCentivolt = 9'h12c;
      3'h7: targetCentivolt = 9'h14a;
      default: targetCentivolt = 9'h0b4;
    endcase
  end

endmodule // dcdcc_output_voltage_select_decode

`default_nettype wire

// ---- dcdcc_converter_control.v ----
/*
  Converter control register block: holds the control, configuration and
  mode registers and drives the analog converter with static levels.
  Assumes a single-cycle special-function bus on the core clock; reads are
  returned one cycle after the read strobe.
*/
// What this block does
// R01: Low-power bit lowers bias and current limit
// R02: Passive-diode bit disables bypass switch control
// R03: Pulse width codes: none, 20, 40, 80 ns
// R04: Bit 5 selects switch size, resets 1
// R05: Software writes reserved bit 4 as zero
// R06: Sync bit aligns ADC tracking and clock
// R07: Software zeroes ADC clock divider before sync
// R08: Voltage code maps 1.8 V to 3.3 V
// R09: Control register at page 0, 0x97, reset 0x21
// R10: Reset values run converter without software
// R11: Low-power enable is configuration bit 7
// R12: Fields are flip-flops driving static levels
`default_nettype none
`include "dcdcc_consts.vh"

module dcdcc_converter_control (
  input wire clk,
  input wire nrst,
  input wire [7:0] sfrPage,
  input wire [7:0] sfrAddr,
  input wire sfrWrite,
  input wire sfrRead,
  input wire [7:0] sfrWdata,
  input wire bypassActive,
  output reg [7:0] sfrRdata,
  output reg sfrRvalid,
  output wire [1:0] minPulseWidth,
  output wire [3:0] minPulseCycles,
  output wire switchSizeSelect,
  output wire adcSyncEnable,
  output wire [2:0] outputVoltageSelect,
  output wire [8:0] targetCentivolt,
  output wire lowPowerEnable,
  output wire reducedBias,
  output wire lowPeakCurrentLimit,
  output wire currentLimitHigh,
  output wire passiveDiodeEnable,
  output wire bypassSwitchCtrlEnable,
  output wire adcTrackInQuiet,
  output wire adcSarClockLocked
);

  // ****************************************
  // Address decode
  // ****************************************
  function hit;
    input [7:0] page;
    input [7:0] addr;
    input [7:0] wantPage;
    input [7:0] wantAddr;
    begin
      hit = (page == wantPage) && (addr == wantAddr);
    end
  endfunction

  wire selCtrl = hit(sfrPage, sfrAddr, `DCDCC_PAGE_MAIN, `DCDCC_ADDR_CTRL); // R09
  wire selCfg = hit(sfrPage, sfrAddr, `DCDCC_PAGE_MAIN, `DCDCC_ADDR_CFG); // R11
  wire selMode = hit(sfrPage, sfrAddr, `DCDCC_PAGE_MODE, `DCDCC_ADDR_MODE);

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] ctrl_reg;
  reg [7:0] cfg_reg;
  reg [7:0] mode_reg;
  reg bypSync1_reg;
  reg bypSync2_reg;
  reg bypSync3_reg;
  reg bypFlag_reg;
  reg [7:0] rdata_next;

  // ****************************************
  // Write enables
  // ****************************************
  // Static levels move only on a write to their own page and address
  wire wrCtrl = sfrWrite && selCtrl;
  wire wrCfg = sfrWrite && selCfg;
  wire wrMode = sfrWrite && selMode;

  // Reset values alone give a working converter: small switches, 1.9 V
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ctrl_reg <= `DCDCC_CTRL_RESET; // R09 R10 R04
    else if (wrCtrl)
      ctrl_reg <= sfrWdata; // R12
  end

  // Low-power mode stays off until software asks for it
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cfg_reg <= `DCDCC_CFG_RESET; // R10
    else if (wrCfg)
      cfg_reg <= sfrWdata; // R12
  end

  // Upper mode bits are not storage; masking keeps bits 7:3 of mode_reg at zero
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mode_reg <= `DCDCC_MODE_RESET; // R10
    else if (wrMode)
      mode_reg <= sfrWdata & `DCDCC_MODE_WMASK; // R12
  end

  // ****************************************
  // Bypass indicator synchroniser
  // ****************************************
  // The flag comes from the analog comparator with no relation to clk.
  // Only the second stage reads the first; a change is taken once the
  // second and third stages agree, at the cost of one more cycle.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bypSync1_reg <= 1'h0;
      bypSync2_reg <= 1'h0;
      bypSync3_reg <= 1'h0;
      bypFlag_reg <= 1'h0;
    end
    else
    begin
      bypSync1_reg <= bypassActive;
      bypSync2_reg <= bypSync1_reg;
      bypSync3_reg <= bypSync2_reg;
      if (bypSync2_reg == bypSync3_reg)
        bypFlag_reg <= bypSync3_reg;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Unused mode bits read as zero; bit 3 is the synchronised bypass flag
  wire [7:0] modeReadWord = {4'h0, bypFlag_reg, mode_reg[2:0]};

  // Read data is registered and then holds, so a late look still sees it
  always @*
  begin
    rdata_next = 8'h00;
    if (selCtrl)
      rdata_next = ctrl_reg;
    else if (selCfg)
      rdata_next = cfg_reg;
    else if (selMode)
      rdata_next = modeReadWord;
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sfrRdata <= 8'h00;
      sfrRvalid <= 1'b0;
    end
    else
    begin
      sfrRvalid <= sfrRead;
      if (sfrRead)
        sfrRdata <= rdata_next;
    end
  end

  // ****************************************
  // Converter control levels
  // ****************************************
  assign minPulseWidth = ctrl_reg[`DCDCC_CTRL_PULSE_HI:`DCDCC_CTRL_PULSE_LO]; // R03

  // ****************************************
  // Minimum pulse width
  // ****************************************
  // Widths are rounded up to whole core cycles, so the switch is never on
  // for less than asked; at 50 ns the 20 ns and 40 ns codes both give one
  localparam integer PULSE1_CYC_INT = `DCDCC_NS_TO_CYC(`DCDCC_PULSE1_NS);
  localparam integer PULSE2_CYC_INT = `DCDCC_NS_TO_CYC(`DCDCC_PULSE2_NS);
  localparam integer PULSE3_CYC_INT = `DCDCC_NS_TO_CYC(`DCDCC_PULSE3_NS);
  localparam [3:0] PULSE1_CYC = PULSE1_CYC_INT[3:0];
  localparam [3:0] PULSE2_CYC = PULSE2_CYC_INT[3:0];
  localparam [3:0] PULSE3_CYC = PULSE3_CYC_INT[3:0];

  // Code 00 means no minimum at all
  function [3:0] pulse_cycles;
    input [1:0] code;
    begin
      case (code)
        2'h1: pulse_cycles = PULSE1_CYC;
        2'h2: pulse_cycles = PULSE2_CYC;
        2'h3: pulse_cycles = PULSE3_CYC;
        default: pulse_cycles = 4'h0;
      endcase
    end
  endfunction

  assign minPulseCycles = pulse_cycles(minPulseWidth); // R03

  // ****************************************
  // Switch, sync and output voltage
  // ****************************************
  assign switchSizeSelect = ctrl_reg[`DCDCC_CTRL_SWSIZE]; // R04
  assign adcSyncEnable = ctrl_reg[`DCDCC_CTRL_SYNC]; // R06
  // Divider must already be zero when sync is set; not checked here
  assign adcTrackInQuiet = adcSyncEnable; // R06
  assign adcSarClockLocked = adcSyncEnable; // R06
  assign outputVoltageSelect = ctrl_reg[`DCDCC_CTRL_VOLT_HI:`DCDCC_CTRL_VOLT_LO]; // R08

  dcdcc_output_voltage_select_decode targetDecode (
    .code(outputVoltageSelect),
    .targetCentivolt(targetCentivolt)
  ); // R08

  // ****************************************
  // Configuration and mode levels
  // ****************************************
  // One enable drives both the bias and the low peak current-limit controls; currentLimitHigh has its own bit
  assign lowPowerEnable = cfg_reg[`DCDCC_CFG_LOW_POWER]; // R11
  assign reducedBias = lowPowerEnable; // R01
  assign lowPeakCurrentLimit = lowPowerEnable; // R01
  assign currentLimitHigh = cfg_reg[`DCDCC_CFG_PEAK_LIMIT]; // R12
  assign passiveDiodeEnable = mode_reg[`DCDCC_MODE_PASSIVE_DIODE]; // R02
  assign bypassSwitchCtrlEnable = ~passiveDiodeEnable; // R02

endmodule // dcdcc_converter_control

`default_nettype wire

// ---- dcdcc_ctrl_monitor.sv ----
/* Port assertions for the converter control block.
   Assumes a bind onto dcdcc_converter_control. */
`default_nettype none
module dcdcc_ctrl_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] sfrPage,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWdata,
  input wire logic [1:0] minPulseWidth,
  input wire logic [3:0] minPulseCycles,
  input wire logic switchSizeSelect,
  input wire logic [2:0] outputVoltageSelect,
  input wire logic [8:0] targetCentivolt,
  input wire logic lowPowerEnable,
  input wire logic reducedBias,
  input wire logic lowPeakCurrentLimit,
  input wire logic passiveDiodeEnable,
  input wire logic bypassSwitchCtrlEnable
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [8:0] VT [8] = '{9'hb4, 9'hbe, 9'hc8, 9'hd2, 9'hf0, 9'h10e, 9'h12c, 9'h14a};
  wire ctrlHit = sfrWrite && sfrPage == 8'h00 && sfrAddr == 8'h97;
  wire cfgHit = sfrWrite && sfrPage == 8'h00 && sfrAddr == 8'h96;
  wire modeHit = sfrWrite && sfrPage == 8'h0f && sfrAddr == 8'h94;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ******
  // Properties
  // ******
  sequence ctrlWr;
    ctrlHit;
  endsequence
  sequence cfgWr;
    cfgHit;
  endsequence
  pw_cycles_a: assert property (minPulseCycles == (minPulseWidth == 2'h3 ? 4'h2 : {3'h0, |minPulseWidth}))
    else $error("pulse cycles wrong");
  ctrl_write_a: assert property (ctrlWr |=> {minPulseWidth, switchSizeSelect} == $past(sfrWdata[7:5])
    && outputVoltageSelect == $past(sfrWdata[2:0])) else $error("control write lost");
  ctrl_hold_a: assert property (!ctrlHit |=> $stable({minPulseWidth, switchSizeSelect, outputVoltageSelect}))
    else $error("control changed without write");
  volt_map_a: assert property (targetCentivolt == VT[outputVoltageSelect]) else $error("target wrong");
  lp_tie_a: assert property (reducedBias == lowPowerEnable && lowPeakCurrentLimit == lowPowerEnable)
    else $error("low power split");
  cfg_write_a: assert property (cfgWr |=> lowPowerEnable == $past(sfrWdata[7])) else $error("lp write lost");
  pd_write_a: assert property (modeHit |=> passiveDiodeEnable == $past(sfrWdata[0]))
    else $error("diode write lost");
  pd_ctrl_a: assert property (bypassSwitchCtrlEnable == !passiveDiodeEnable) else $error("bypass ctrl wrong");
endmodule // dcdcc_ctrl_monitor
bind dcdcc_converter_control dcdcc_ctrl_monitor u_mon (
  .clk(clk),
  .nrst(nrst),
  .sfrPage(sfrPage),
  .sfrAddr(sfrAddr),
  .sfrWrite(sfrWrite),
  .sfrWdata(sfrWdata),
  .minPulseWidth(minPulseWidth),
  .minPulseCycles(minPulseCycles),
  .switchSizeSelect(switchSizeSelect),
  .outputVoltageSelect(outputVoltageSelect),
  .targetCentivolt(targetCentivolt),
  .lowPowerEnable(lowPowerEnable),
  .reducedBias(reducedBias),
  .lowPeakCurrentLimit(lowPeakCurrentLimit),
  .passiveDiodeEnable(passiveDiodeEnable),
  .bypassSwitchCtrlEnable(bypassSwitchCtrlEnable)
);
`default_nettype wire

// ---- tb_dcdc_converter_control.sv ----
/* Self-checking bench for the converter control block.
   Assumes the block and its monitor are compiled first. */
`default_nettype none
module tb_dcdc_converter_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, nrst = 1'h0, sfrWrite = 1'h0, sfrRead = 1'h0, bypassActive = 1'h0;
  logic [7:0] sfrPage = 8'h0, sfrAddr = 8'h0, sfrWdata = 8'h0;
  wire [7:0] sfrRdata;
  wire [1:0] minPulseWidth;
  wire [3:0] minPulseCycles;
  wire [2:0] outputVoltageSelect;
  wire [8:0] targetCentivolt;
  wire sfrRvalid, switchSizeSelect, adcSyncEnable, lowPowerEnable, reducedBias, lowPeakCurrentLimit;
  wire currentLimitHigh, passiveDiodeEnable, bypassSwitchCtrlEnable, adcTrackInQuiet, adcSarClockLocked;
  int n_mismatch = 0, num_checks = 0;
  // Targets in hundredths of a volt, 1.8 V to 3.3 V
  localparam logic [8:0] VOLT_TABLE [8] = '{9'hb4, 9'hbe, 9'hc8, 9'hd2, 9'hf0, 9'h10e, 9'h12c, 9'h14a};
  dcdcc_converter_control dut (.*);
  initial forever #25 clk = ~clk;
  // ******
  // Bus tasks
  // ******
  task chk(string n, logic [8:0] s, logic [8:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task wr(logic [7:0] p, a, d);
    @(posedge clk);
    {sfrPage, sfrAddr, sfrWdata, sfrWrite} <= {p, a, d, 1'h1};
    @(posedge clk);
    sfrWrite <= 1'h0;
    @(posedge clk);
    #1;
  endtask
  task rd(logic [7:0] p, a, e);
    @(posedge clk);
    {sfrPage, sfrAddr, sfrRead} <= {p, a, 1'h1};
    @(posedge clk);
    sfrRead <= 1'h0;
    #1;
    for (int i = 0; i < 3 && sfrRvalid !== 1'h1; i++) @(posedge clk) #1;
    chk("rvalid", sfrRvalid, 1'h1);
    chk("rdata", sfrRdata, e);
  endtask
  // ******
  // Scenarios
  // ******
  task t_reset;
    rd(8'h00, 8'h97, 8'h21);
    chk("swsize", switchSizeSelect, 1'h1);
    chk("pwfield", minPulseWidth, 9'h0);
    chk("target", targetCentivolt, 9'hbe);
    chk("bypctl", bypassSwitchCtrlEnable, 1'h1);
    $display("t_reset done");
  endtask
  task t_pw;
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h00, 8'h97, 8'(c << 6));
      chk("pwfield", minPulseWidth, 9'(c));
      chk("pwcycles", minPulseCycles, (c == 3) ? 9'h2 : 9'(c != 0));
    end
    chk("swsize", switchSizeSelect, 1'h0);
    $display("t_pw done");
  endtask
  task t_output_voltage_select;
    for (int v = 0; v < 8; v++)
    begin
      // Sync is set on odd codes; the divider outside is taken as zero first
      wr(8'h00, 8'h97, 8'(v | (v[0] << 3)));
      chk("target", targetCentivolt, VOLT_TABLE[v]);
      chk("sync", adcSyncEnable, v[0]);
      chk("track", adcTrackInQuiet, v[0]);
      chk("lock", adcSarClockLocked, v[0]);
    end
    $display("t_output_voltage_select done");
  endtask
  task t_cfg;
    wr(8'h00, 8'h96, 8'h84);
    chk("bias", reducedBias, 1'h1);
    chk("ilim", lowPeakCurrentLimit, 1'h1);
    chk("peak", currentLimitHigh, 1'h1);
    rd(8'h00, 8'h96, 8'h84);
    wr(8'h00, 8'h96, 8'h00);
    chk("lowpow", lowPowerEnable, 1'h0);
    chk("bias", reducedBias, 1'h0);
    chk("peak", currentLimitHigh, 1'h0);
    $display("t_cfg done");
  endtask
  task t_mode;
    wr(8'h0f, 8'h94, 8'hff);
    chk("pden", passiveDiodeEnable, 1'h1);
    chk("bypctl", bypassSwitchCtrlEnable, 1'h0);
    rd(8'h0f, 8'h94, 8'h07);
    @(posedge clk);
    bypassActive <= 1'h1;
    repeat (5) @(posedge clk);
    rd(8'h0f, 8'h94, 8'h0f);
    $display("t_mode done");
  endtask
  task t_unmap;
    wr(8'h0f, 8'h97, 8'h00);
    chk("voltsel", outputVoltageSelect, 3'h7);
    rd(8'h00, 8'h55, 8'h00);
    $display("t_unmap done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #100us;
    n_mismatch++;
    tally_and_finish;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    nrst <= 1'h1;
    t_reset;
    t_pw;
    t_output_voltage_select;
    t_cfg;
    t_mode;
    t_unmap;
    tally_and_finish;
  end
endmodule // tb_dcdc_converter_control
`default_nettype wire
